/* File: include/smc_consts.svh */
// Constants for the shared memory controller: timing, refresh and config layout.
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_CLK_MHZ        125
`define SMC_RFSH_EDO_NS    14000
`define SMC_RFSH_SD_NS     14500
`define SMC_RFSH_EDO_CYC   ((`SMC_RFSH_EDO_NS * `SMC_CLK_MHZ) / 1000)
`define SMC_RFSH_SD_CYC    ((`SMC_RFSH_SD_NS * `SMC_CLK_MHZ) / 1000)
`define SMC_EDO_FIRST      4'h8
`define SMC_EDO_NEXT       4'h4
`define SMC_EDO_SINGLE     4'h7
`define SMC_EDO_RFSH       4'h6
`define SMC_SD_FIRST       4'h3
`define SMC_SD_NEXT        4'h1
`define SMC_SD_SINGLE      4'h4
`define SMC_SD_RFSH        4'h8
`define SMC_BURST_BEATS    2'h3
`define SMC_FIFO_DEPTH     8
`define SMC_CFG_CTRL       8'h00
`define SMC_CFG_CORR_CNT   8'h01
`define SMC_CFG_UNC_CNT    8'h02
`define SMC_CTRL_ECC_BIT   0
`define SMC_CTRL_TYPE_BIT  1
`define SMC_CTRL_RESET     8'h01
`endif

/* File: include/smc_pkg.sv */
// Types shared by the shared memory controller, its assertions and its testbench.
package smc_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        burst;
    logic [7:0]  byteEn;
    logic [63:0] wdata;
  } smc_req_t;
  typedef struct packed {
    logic [63:0] data;
    logic        corrected;
    logic        uncorrectable;
  } smc_rsp_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_RFSH} smc_state_t;
endpackage

/* File: core/smc_ctrl.sv */
// Shared memory controller with ECC, refresh, indirect config and a request FIFO.
// Operation
// - Correct single-bit errors before returning read data.
// - Flag double errors, never correct; three-bit nibble errors can pass as corrected.
// - ECC on after reset, software may disable.
// - ECC only on page-mode; synchronous has none.
// - Non-ECC reads fetch requested bytes, discard rest.
// - Non-ECC partial writes mask unaddressed bytes.
// - ECC partial reads widen to aligned word.
// - ECC partial writes become read-modify-write.
// - Line fills are four 8-byte beats.
// - Page-mode burst timing 8-4-4-4, 20 clocks.
// - Page-mode single access takes 7 clocks.
// - Page-mode refresh every 14 us, six clocks.
// - Synchronous burst timing 3-1-1-1, 6 clocks.
// - Synchronous single access takes 4 clocks.
// - Synchronous refresh every 14.5 us, eight clocks.
// - Config reached through pointer and data window.
`timescale 1ns/1ps
`include "smc_consts.svh"

module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,  // Clock.
  input  wire logic             rst,      // Asynchronous reset, active high.
  input  wire logic             inValid,  // Write side offers a word.
  output logic                  inReady,  // Room for a word.
  input  wire logic [WIDTH-1:0] inData,   // Word written.
  output logic                  outValid, // A word is held.
  input  wire logic             outReady, // Read side takes the word.
  output logic      [WIDTH-1:0] outData   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrIdx_reg;
  logic [AW-1:0]    rdIdx_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      countNext;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdIdx_reg];

  always_comb begin
    countNext = count_reg;
    if (push && !pop) begin
      countNext = count_reg + 1'b1;
    end else if (pop && !push) begin
      countNext = count_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      inReady   <= 1'b1;
      outValid  <= 1'b0;
    end else begin
      count_reg <= countNext;
      inReady   <= countNext != (AW+1)'(DEPTH);
      outValid  <= countNext != '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrIdx_reg <= '0;
      rdIdx_reg <= '0;
    end else begin
      if (push) begin
        wrIdx_reg <= (wrIdx_reg == AW'(DEPTH - 1)) ? '0 : wrIdx_reg + 1'b1;
      end
      if (pop) begin
        rdIdx_reg <= (rdIdx_reg == AW'(DEPTH - 1)) ? '0 : rdIdx_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wrIdx_reg] <= inData;
    end
  end
endmodule

module smc_ctrl
  import smc_pkg::*;
(
  input  wire logic        ref_clk,         // 125 MHz clock.
  input  wire logic        rst,             // Asynchronous reset, active high.
  input  wire logic        reqValid,        // Master offers a request.
  output logic             reqReady,        // Request buffer has room.
  input  wire smc_req_t    reqData,         // Request.
  output logic             rspValid,        // One read beat returned.
  output smc_rsp_t         rspData,         // Read data and error flags.
  input  wire logic        cfgWr,           // Config write strobe.
  input  wire logic        cfgRd,           // Config read strobe.
  input  wire logic        cfgWin,          // 0 pointer, 1 data window.
  input  wire logic [7:0]  cfgWdata,        // Config write data.
  output logic      [7:0]  cfgRdata,        // Config read data.
  output logic             memStrobe,       // Start of a memory beat.
  output logic             memWrite,        // Beat is a write.
  output logic      [31:0] memAddr,         // Beat address, 8-byte aligned.
  output logic      [7:0]  memByteEn,       // Byte lanes used.
  output logic      [63:0] memWdata,        // Write data.
  output logic      [7:0]  memCheckOut,     // Write check byte.
  output logic             memRefresh,      // Refresh start pulse.
  input  wire logic [63:0] memRdata,        // Read data at beat end.
  input  wire logic [7:0]  memCheckIn       // Read check byte at beat end.
);
  smc_state_t  state_reg;
  smc_req_t    cur_reg;
  smc_req_t    fifoOut;
  logic        fifoValid;
  logic        fifoTake;
  logic [3:0]  cnt_reg;
  logic [1:0]  beat_reg;
  logic        rmw_reg;
  logic [10:0] rfTimer_reg;
  logic        rfPend_reg;
  logic        rfDue;
  logic [7:0]  ptr_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  corrCnt_reg;
  logic [7:0]  uncCnt_reg;
  logic        eccOn;
  logic        sdram;
  logic        beatDone;
  smc_rsp_t    fixed;
  logic [63:0] merged;

  // Column of the parity check matrix for data bit idx: odd weight of three or more.
  function automatic logic [7:0] eccCol(input int idx);
    int          n;
    logic [7:0]  v;
    logic [7:0]  r;
    n = 0;
    r = '0;
    for (int k = 0; k < 256; k++) begin
      v = 8'(k);
      if ($countones(v) >= 3 && $countones(v) % 2 == 1) begin
        if (n == idx) begin
          r = v;
        end
        n++;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] eccGen(input logic [63:0] d);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < 64; i++) begin
      if (d[i]) begin
        c = c ^ eccCol(i);
      end
    end
    return c;
  endfunction

  function automatic smc_rsp_t eccFix(input logic [63:0] d, input logic [7:0] chk);
    smc_rsp_t   r;
    logic [7:0] s;
    s = eccGen(d) ^ chk;
    r.data = d;
    r.corrected = 1'b0;
    r.uncorrectable = 1'b0;
    if (s != '0) begin
      r.uncorrectable = 1'b1;
      if ($countones(s) == 1) begin
        r.uncorrectable = 1'b0;
        r.corrected = 1'b1;
      end
      for (int i = 0; i < 64; i++) begin
        if (eccCol(i) == s) begin
          r.data[i] = ~d[i];
          r.corrected = 1'b1;
          r.uncorrectable = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] laneMask(input logic [7:0] be);
    logic [63:0] m;
    for (int i = 0; i < 8; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Cycle count minus one for a beat: 0 single, 1 first of burst, 2 later beat.
  function automatic logic [3:0] beatLen(input logic [1:0] kind, input logic sd);
    logic [3:0] l;
    unique case (kind)
      2'h1: l = sd ? `SMC_SD_FIRST : `SMC_EDO_FIRST;
      2'h2: l = sd ? `SMC_SD_NEXT : `SMC_EDO_NEXT;
      default: l = sd ? `SMC_SD_SINGLE : `SMC_EDO_SINGLE;
    endcase
    return l - 4'h1;
  endfunction

  smc_fifo #(.WIDTH($bits(smc_req_t)), .DEPTH(`SMC_FIFO_DEPTH)) reqFifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   (reqData),
    .outValid (fifoValid),
    .outReady (fifoTake),
    .outData  (fifoOut)
  );

  assign sdram = ctrl_reg[`SMC_CTRL_TYPE_BIT];
  assign eccOn = ctrl_reg[`SMC_CTRL_ECC_BIT] && !sdram;
  assign fifoTake = state_reg == ST_IDLE && !rfPend_reg && fifoValid;
  assign beatDone = state_reg == ST_READ && cnt_reg == 4'h0;
  assign fixed = eccOn ? eccFix(memRdata, memCheckIn) : smc_rsp_t'{memRdata, 1'b0, 1'b0};
  assign merged = (fixed.data & ~laneMask(cur_reg.byteEn))
                | (cur_reg.wdata & laneMask(cur_reg.byteEn));
  assign rfDue = rfTimer_reg == 11'h000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rfTimer_reg <= 11'(`SMC_RFSH_EDO_CYC - 1);
    end else if (rfDue) begin
      rfTimer_reg <= sdram ? 11'(`SMC_RFSH_SD_CYC - 1) : 11'(`SMC_RFSH_EDO_CYC - 1);
    end else begin
      rfTimer_reg <= rfTimer_reg - 11'h001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rfPend_reg <= 1'b0;
    end else if (rfDue) begin
      rfPend_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      rfPend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      cur_reg     <= '0;
      cnt_reg     <= 4'h0;
      beat_reg    <= 2'h0;
      rmw_reg     <= 1'b0;
      memStrobe   <= 1'b0;
      memWrite    <= 1'b0;
      memAddr     <= 32'h00000000;
      memByteEn   <= 8'h00;
      memWdata    <= 64'h0000000000000000;
      memCheckOut <= 8'h00;
      memRefresh  <= 1'b0;
    end else begin
      memStrobe  <= 1'b0;
      memRefresh <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (rfPend_reg) begin
            state_reg  <= ST_RFSH;
            memRefresh <= 1'b1;
            cnt_reg    <= (sdram ? `SMC_SD_RFSH : `SMC_EDO_RFSH) - 4'h1;
          end else if (fifoValid) begin
            cur_reg   <= fifoOut;
            beat_reg  <= 2'h0;
            memStrobe <= 1'b1;
            memAddr   <= {fifoOut.addr[31:3], 3'h0};
            if (fifoOut.write && !(eccOn && fifoOut.byteEn != 8'hff)) begin
              state_reg   <= ST_WRITE;
              rmw_reg     <= 1'b0;
              memWrite    <= 1'b1;
              memByteEn   <= fifoOut.byteEn;
              memWdata    <= fifoOut.wdata;
              memCheckOut <= eccOn ? eccGen(fifoOut.wdata) : 8'h00;
              cnt_reg     <= beatLen(2'h0, sdram);
            end else begin
              state_reg <= ST_READ;
              rmw_reg   <= fifoOut.write;
              memWrite  <= 1'b0;
              memByteEn <= (eccOn || fifoOut.burst) ? 8'hff : fifoOut.byteEn;
              if (fifoOut.burst && !fifoOut.write) begin
                memAddr <= {fifoOut.addr[31:5], 5'h00};
                cnt_reg <= beatLen(2'h1, sdram);
              end else begin
                cnt_reg <= beatLen(2'h0, sdram);
              end
            end
          end
        end
        ST_READ: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (rmw_reg) begin
            state_reg   <= ST_WRITE;
            memStrobe   <= 1'b1;
            memWrite    <= 1'b1;
            memByteEn   <= 8'hff;
            memWdata    <= merged;
            memCheckOut <= eccGen(merged);
            cnt_reg     <= beatLen(2'h0, sdram);
          end else if (cur_reg.burst && beat_reg != `SMC_BURST_BEATS) begin
            beat_reg  <= beat_reg + 2'h1;
            memStrobe <= 1'b1;
            memAddr   <= memAddr + 32'h00000008;
            cnt_reg   <= beatLen(2'h2, sdram);
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            state_reg <= ST_IDLE;
            memWrite  <= 1'b0;
          end
        end
        ST_RFSH: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= beatDone && !rmw_reg;
      if (beatDone && !rmw_reg) begin
        rspData.data <= fixed.data
                      & (cur_reg.burst ? {64{1'b1}} : laneMask(cur_reg.byteEn));
        rspData.corrected     <= fixed.corrected;
        rspData.uncorrectable <= fixed.uncorrectable;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_reg     <= 8'h00;
      ctrl_reg    <= `SMC_CTRL_RESET;
      corrCnt_reg <= 8'h00;
      uncCnt_reg  <= 8'h00;
      cfgRdata    <= 8'h00;
    end else begin
      if (beatDone && fixed.corrected && corrCnt_reg != 8'hff) begin
        corrCnt_reg <= corrCnt_reg + 8'h01;
      end else if (cfgWr && cfgWin && ptr_reg == `SMC_CFG_CORR_CNT) begin
        corrCnt_reg <= 8'h00;
      end
      if (beatDone && fixed.uncorrectable && uncCnt_reg != 8'hff) begin
        uncCnt_reg <= uncCnt_reg + 8'h01;
      end else if (cfgWr && cfgWin && ptr_reg == `SMC_CFG_UNC_CNT) begin
        uncCnt_reg <= 8'h00;
      end
      if (cfgWr && !cfgWin) begin
        ptr_reg <= cfgWdata;
      end
      if (cfgWr && cfgWin && ptr_reg == `SMC_CFG_CTRL) begin
        ctrl_reg <= cfgWdata & 8'h03;
      end
      if (cfgRd) begin
        if (!cfgWin) begin
          cfgRdata <= ptr_reg;
        end else begin
          unique case (ptr_reg)
            `SMC_CFG_CTRL:     cfgRdata <= ctrl_reg;
            `SMC_CFG_CORR_CNT: cfgRdata <= corrCnt_reg;
            `SMC_CFG_UNC_CNT:  cfgRdata <= uncCnt_reg;
            default:           cfgRdata <= 8'h00;
          endcase
        end
      end
    end
  end
endmodule

/* File: verif/smc_ctrl_properties.sv */
// Port assertions and covers for the shared memory controller.
`timescale 1ns/1ps
module smc_ctrl_properties
  import smc_pkg::*;
(
  input wire logic        ref_clk,    // Clock.
  input wire logic        rst,        // Reset, active high.
  input wire logic        rspValid,   // Read beat returned.
  input wire smc_rsp_t    rspData,    // Read data and flags.
  input wire logic        cfgWr,      // Config write strobe.
  input wire logic        cfgRd,      // Config read strobe.
  input wire logic        cfgWin,     // Pointer or window.
  input wire logic [7:0]  cfgWdata,   // Config write data.
  input wire logic [7:0]  cfgRdata,   // Config read data.
  input wire logic        memStrobe,  // Beat start.
  input wire logic        memWrite,   // Write beat.
  input wire logic [31:0] memAddr,    // Beat address.
  input wire logic        memRefresh  // Refresh start.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RSP_LAT: assert property (
    rspValid |-> $past(memStrobe, 1) || $past(memStrobe, 3) || $past(memStrobe, 4)
      || $past(memStrobe, 7) || $past(memStrobe, 8)) else $error("response off beat end");
  AST_REFRESH_BUSY: assert property (
    memRefresh |=> !memStrobe [*6]) else $error("beat during refresh");
  AST_REFRESH_ALONE: assert property (
    memRefresh |-> !memStrobe && !rspValid) else $error("refresh overlaps a beat");
  AST_WRITE_SILENT: assert property (
    memStrobe && memWrite |-> !rspValid) else $error("response on write beat");
  AST_ALIGNED: assert property (
    memStrobe |-> memAddr[2:0] == 3'h0) else $error("beat address unaligned");
  // Pointer value as last written by the master, for the readback check.
  logic [7:0] ptrSeen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptrSeen <= 8'h00;
    end else if (cfgWr && !cfgWin) begin
      ptrSeen <= cfgWdata;
    end
  end
  AST_CFG_PTR: assert property (
    cfgRd && !cfgWin |=> cfgRdata == $past(ptrSeen))
    else $error("pointer readback wrong");
  AST_FLAGS: assert property (
    rspValid |-> !(rspData.corrected && rspData.uncorrectable)) else $error("both flags set");
  AST_RSP_HOLD: assert property (
    !rspValid |-> $stable(rspData)) else $error("response changed without valid");
  COV_CORR: cover property (rspValid && rspData.corrected);
  COV_RFSH: cover property (memRefresh);
  COV_WR: cover property (memStrobe && memWrite);
endmodule
bind smc_ctrl smc_ctrl_properties u_smc_ctrl_properties (.ref_clk, .rst, .rspValid, .rspData,
  .cfgWr, .cfgRd, .cfgWin, .cfgWdata, .cfgRdata, .memStrobe, .memWrite, .memAddr, .memRefresh);

/* File: verif/smc_mem_model.sv */
// Behavioural memory module answering the controller's beats.
`timescale 1ns/1ps
module smc_mem_model (
  input  wire logic        ref_clk,     // Clock.
  input  wire logic        memStrobe,   // Beat start.
  input  wire logic        memWrite,    // Write beat.
  input  wire logic [31:0] memAddr,     // Beat address.
  input  wire logic [7:0]  memByteEn,   // Byte lanes.
  input  wire logic [63:0] memWdata,    // Write data.
  input  wire logic [7:0]  memCheckOut, // Write check byte.
  input  wire logic [63:0] flipMask,    // Data bits corrupted on reads.
  output logic      [63:0] memRdata,    // Read data.
  output logic      [7:0]  memCheckIn   // Read check byte.
);
  logic [71:0] store [32];
  logic [4:0]  idx;
  assign idx = memAddr[7:3];
  always @(posedge ref_clk) begin
    if (memStrobe && memWrite) begin
      for (int i = 0; i < 8; i++) begin
        if (memByteEn[i]) begin
          store[idx][8*i +: 8] <= memWdata[8*i +: 8];
        end
      end
      store[idx][71:64] <= memCheckOut;
    end
  end
  // During a write beat the read data lines show the inverse so a stray sample is caught.
  always_comb begin
    memRdata = store[idx][63:0] ^ flipMask;
    memCheckIn = store[idx][71:64];
    if (memWrite) begin
      memRdata = ~memRdata;
    end
  end
endmodule

/* File: verif/smc_ctrl_test.sv */
// Self-checking testbench for the shared memory controller.
`timescale 1ns/1ps
module smc_ctrl_test
  import smc_pkg::*;
;
  typedef struct {int c; logic w; logic [31:0] a; logic [7:0] b;} smc_beat_t;
  logic ref_clk, rst, reqValid, reqReady, rspValid, cfgWr, cfgRd, cfgWin;
  logic memStrobe, memWrite, memRefresh, full;
  smc_req_t    reqData;
  smc_rsp_t    rspData;
  logic [7:0]  cfgWdata, cfgRdata, memByteEn, memCheckOut, memCheckIn;
  logic [31:0] memAddr;
  logic [63:0] memWdata, memRdata, flipMask;
  smc_beat_t   sq[$];
  smc_rsp_t    rq[$];
  int          rc[$], fc[$];
  int          cyc, fails, compares;
  smc_ctrl u_smc_ctrl (.ref_clk, .rst, .reqValid, .reqReady, .reqData, .rspValid, .rspData,
    .cfgWr, .cfgRd, .cfgWin, .cfgWdata, .cfgRdata, .memStrobe, .memWrite, .memAddr,
    .memByteEn, .memWdata, .memCheckOut, .memRefresh, .memRdata, .memCheckIn);
  smc_mem_model u_smc_mem_model (.ref_clk, .memStrobe, .memWrite, .memAddr, .memByteEn,
    .memWdata, .memCheckOut, .flipMask, .memRdata, .memCheckIn);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    #1;
    cyc++;
    if (memStrobe === 1'b1) sq.push_back('{cyc, memWrite, memAddr, memByteEn});
    if (rspValid === 1'b1) begin
      rq.push_back(rspData);
      rc.push_back(cyc);
    end
    if (memRefresh === 1'b1) fc.push_back(cyc);
    if (reqReady === 1'b0) full = 1'b1;
  end
  function automatic logic [63:0] pat(int i);
    return 64'h0123_4567_89ab_cdef + 64'h1111_1111_1111_1111 * i;
  endfunction
  task chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task clr();
    sq.delete();
    rq.delete();
    rc.delete();
  endtask
  // Leaves reqValid high; wt lowers it before the next idle span.
  task send(logic [31:0] a, logic w, logic b, logic [7:0] be, logic [63:0] d);
    reqData <= '{a, w, b, be, d};
    reqValid <= 1'b1;
    do @(posedge ref_clk); while (reqReady !== 1'b1);
  endtask
  task wt(int n);
    reqValid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task cfg(logic wr, logic win, logic [7:0] d);
    cfgWr <= wr;
    cfgRd <= !wr;
    cfgWin <= win;
    cfgWdata <= d;
    @(posedge ref_clk);
    cfgWr <= 1'b0;
    cfgRd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task t_cfg();
    cfg(1, 0, 8'h00);
    cfg(0, 1, 8'h00);
    chk("ctrl", 8'h01, cfgRdata);
    cfg(1, 0, 8'h02);
    cfg(0, 0, 8'h00);
    chk("pointer", 8'h02, cfgRdata);
    $display("config test done");
  endtask
  task t_ecc();
    clr();
    for (int i = 0; i < 4; i++) send(32'h100 + 8 * i, 1, 0, 8'hff, pat(i));
    send(32'h108, 0, 0, 8'hf0, 0);
    wt(80);
    chk("beats", 5, sq.size());
    chk("rsps", 1, rq.size());
    if (sq.size() == 5 && rq.size() == 1) begin
      chk("be", 8'hff, sq[4].b);
      chk("latency", 7, rc[0] - sq[4].c);
      chk("data", pat(1) & 64'hffff_ffff_0000_0000, rq[0].data);
    end
    clr();
    flipMask <= 64'h1;
    send(32'h100, 0, 0, 8'hff, 0);
    wt(20);
    flipMask <= 64'h3;
    send(32'h100, 0, 0, 8'hff, 0);
    wt(20);
    flipMask <= 64'h0;
    chk("rsps", 2, rq.size());
    if (rq.size() == 2) begin
      chk("fixed", pat(0), rq[0].data);
      chk("corr", 1, rq[0].corrected);
      chk("unc", 1, rq[1].uncorrectable);
      chk("corr2", 0, rq[1].corrected);
    end
    clr();
    send(32'h110, 1, 0, 8'h0f, 64'hffff_ffff_ffff_ffff);
    send(32'h110, 0, 0, 8'hff, 0);
    wt(60);
    chk("beats", 3, sq.size());
    chk("rsps", 1, rq.size());
    if (sq.size() == 3 && rq.size() == 1) begin
      chk("rmw", 2'b01, {sq[0].w, sq[1].w});
      chk("merged", (pat(2) & 64'hffff_ffff_0000_0000) | 64'hffff_ffff, rq[0].data);
      chk("flags", 0, {rq[0].corrected, rq[0].uncorrectable});
    end
    cfg(1, 0, 8'h01);
    cfg(0, 1, 8'h00);
    chk("corr count", 8'h01, cfgRdata);
    cfg(1, 0, 8'h02);
    cfg(0, 1, 8'h00);
    chk("unc count", 8'h01, cfgRdata);
    $display("ecc test done");
  endtask
  task t_off();
    clr();
    cfg(1, 0, 8'h00);
    cfg(1, 1, 8'h00);
    flipMask <= 64'h1;
    send(32'h100, 0, 0, 8'hff, 0);
    wt(24);
    flipMask <= 64'h0;
    chk("off rsps", 1, rq.size());
    if (rq.size() == 1) begin
      chk("off data", pat(0) ^ 64'h1, rq[0].data);
      chk("off corr", 0, rq[0].corrected);
    end
    $display("ecc off test done");
  endtask
  task t_burst(int f, int n);
    clr();
    send(32'h108, 0, 1, 8'hff, 0);
    wt(40);
    chk("beats", 4, rq.size());
    if (rq.size() == 4 && sq.size() == 4) begin
      for (int i = 0; i < 4; i++) begin
        chk("lat", (i == 0) ? f : n, rc[i] - sq[i].c);
        chk("addr", 32'h100 + 8 * i, sq[i].a);
        chk("bdata", pat(i), rq[i].data);
      end
      chk("total", f + 3 * n, rc[3] - sq[0].c);
    end
    $display("burst test done");
  endtask
  task t_fifo();
    full = 1'b0;
    clr();
    for (int i = 0; i < 10; i++) send(32'h200 + 8 * i, 1, 0, 8'hff, pat(i));
    wt(120);
    chk("full", 1, full);
    chk("writes", 10, sq.size());
    chk("ready", 1, reqReady);
    $display("fifo test done");
  endtask
  task t_rf(int p);
    fc.delete();
    for (int i = 0; i < 6000 && fc.size() < 3; i++) @(posedge ref_clk);
    chk("refreshes", 3, fc.size());
    if (fc.size() == 3) chk("period", p, fc[2] - fc[1]);
    $display("refresh test done");
  endtask
  task t_sd();
    clr();
    flipMask <= 64'h1;
    send(32'h100, 0, 0, 8'h0f, 0);
    send(32'h118, 1, 0, 8'h0f, 0);
    wt(30);
    flipMask <= 64'h0;
    chk("beats", 2, sq.size());
    chk("rsps", 1, rq.size());
    if (sq.size() == 2 && rq.size() == 1) begin
      chk("rbe", 8'h0f, sq[0].b);
      chk("lat", 4, rc[0] - sq[0].c);
      chk("raw", (pat(0) ^ 64'h1) & 64'hffff_ffff, rq[0].data);
      chk("corr", 0, rq[0].corrected);
      chk("wbe", 8'h0f, sq[1].b);
      chk("wr", 1, sq[1].w);
    end
    $display("sdram test done");
  endtask
  task end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
  initial begin
    {reqValid, cfgWr, cfgRd, cfgWin, full} = '0;
    {reqData, cfgWdata, flipMask} = '0;
    rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_cfg();
    t_ecc();
    t_fifo();
    t_burst(8, 4);
    t_rf(1750);
    t_off();
    cfg(1, 0, 8'h00);
    cfg(1, 1, 8'h03);
    t_burst(3, 1);
    t_sd();
    t_rf(1812);
    end_sim();
  end
endmodule
